/* rpr_consts.svh */
// Constants for the registered memory read path
`ifndef RPR_CONSTS_SVH
`define RPR_CONSTS_SVH
`define RPR_ADDR_W     9
`define RPR_DATA_W     8
`define RPR_DEPTH      512
`define RPR_BLANK_WORD 8'h00
`endif

/* rpr_pkg.sv */
// Types for the registered memory read path
`include "rpr_consts.svh"
package rpr_pkg;
   typedef logic [`RPR_ADDR_W-1:0] rpr_addr_t;
   typedef logic [`RPR_DATA_W-1:0] rpr_word_t;
   // Three-state output group: value plus low-active enable
   typedef struct packed {
      rpr_word_t data;
      logic      oe_n;
   } rpr_out_t;
   typedef enum logic {RPR_OFF, RPR_ON} rpr_en_state_t;
endpackage

/* rpr_sync2.sv */
// Two flip-flop synchroniser for one pin level
`timescale 1ns/100ps
`default_nettype none
module rpr_sync2 #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   input  wire logic d,
   output logic      q
);
   logic meta;
   logic next_meta;
   logic next_q;

   // Stage shift; first stage feeds only the second
   always_comb begin
      next_meta = clk_en ? d : meta;
      next_q    = clk_en ? meta : q;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= next_meta;
         q    <= next_q;
      end
   end
endmodule // rpr_sync2
`default_nettype wire

/* rpr_fuse_array.sv */
// Fuse array: 512 by 8 contents and the extra preset word
`timescale 1ns/100ps
`default_nettype none
`include "rpr_consts.svh"
module rpr_fuse_array
   import rpr_pkg::*;
#(
   parameter logic [`RPR_DEPTH*`RPR_DATA_W-1:0] CONTENTS    = '0,
   parameter rpr_word_t                         PRESET_WORD = `RPR_BLANK_WORD
) (
   input  wire rpr_addr_t addr,
   input  wire logic      preset_sel_n,
   output rpr_word_t      word
);
   // Constant table; blank parts read all low
   rpr_word_t table_mem [`RPR_DEPTH];
   always_comb begin
      for (int i = 0; i < `RPR_DEPTH; i++) begin
         table_mem[i] = CONTENTS[i*`RPR_DATA_W +: `RPR_DATA_W];
      end
   end

   // Preset word wins over the addressed word
   always_comb begin
      word = preset_sel_n ? table_mem[addr] : PRESET_WORD;
   end
endmodule // rpr_fuse_array
`default_nettype wire

/* registered_prom_read_path.sv */
// Registered memory read path with sync and async output enables
//
// Contract
// - 512 words of 8 bits, 9-bit address
// - Sync enable high at edge: outputs off
// - Async enable high: outputs always off
// - Drive only when both enables low
// - Sync enable flop starts disabled
// - Addressed word feeds the master stage
// - Rising edge moves word to outputs
// - Output word holds until next edge
// - Extra programmable word, low-select pin
// - Preset select loads on next edge
// - Unprogrammed preset word is all zeros
// - Unprogrammed device reads all low
// - Programmed bits never return low
`timescale 1ns/100ps
`default_nettype none
`include "rpr_consts.svh"
module registered_prom_read_path
   import rpr_pkg::*;
#(
   parameter logic [`RPR_DEPTH*`RPR_DATA_W-1:0] CONTENTS    = '0,
   parameter rpr_word_t                         PRESET_WORD = `RPR_BLANK_WORD
) (
   input  wire logic      clk_sys,
   input  wire logic      sys_rst,
   input  wire logic      clk_en,
   input  wire rpr_addr_t word_address,
   input  wire logic      sync_output_enable_n,
   input  wire logic      async_output_enable_n,
   input  wire logic      preset_sel_n,
   output rpr_out_t       data_out
);
   rpr_addr_t     addr_s;
   logic          sync_en_n_s;
   logic          async_en_n_s;
   logic          preset_n_s;
   rpr_word_t     master_word;
   rpr_word_t     slave_word;
   rpr_word_t     next_slave_word;
   rpr_en_state_t en_state;
   rpr_en_state_t next_en_state;

   // Pin inputs pass two flops before use
   for (genvar b = 0; b < `RPR_ADDR_W; b++) begin : g_addr_sync
      rpr_sync2 #(.RST_VAL(1'b0)) u_sync (
         .clk_sys (clk_sys),
         .sys_rst (sys_rst),
         .clk_en  (clk_en),
         .d       (word_address[b]),
         .q       (addr_s[b])
      );
   end

   rpr_sync2 #(.RST_VAL(1'b1)) u_sync_gs (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .d       (sync_output_enable_n),
      .q       (sync_en_n_s)
   );

   // Async enable resets high so outputs start off
   rpr_sync2 #(.RST_VAL(1'b1)) u_sync_g (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .d       (async_output_enable_n),
      .q       (async_en_n_s)
   );

   rpr_sync2 #(.RST_VAL(1'b1)) u_sync_ps (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .d       (preset_sel_n),
      .q       (preset_n_s)
   );

   // Array lookup is the master stage
   rpr_fuse_array #(
      .CONTENTS    (CONTENTS),
      .PRESET_WORD (PRESET_WORD)
   ) u_array (
      .addr         (addr_s),
      .preset_sel_n (preset_n_s),
      .word         (master_word)
   );

   // Slave and enable flop load only on an enabled edge
   always_comb begin
      next_slave_word = slave_word;
      next_en_state   = en_state;
      if (clk_en) begin
         next_slave_word = master_word;
         case (sync_en_n_s)
            1'b1:    next_en_state = RPR_OFF;
            1'b0:    next_en_state = RPR_ON;
            default: next_en_state = RPR_OFF;
         endcase
      end
   end

   // Reset stands in for power-up; register stays blank
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         slave_word <= `RPR_BLANK_WORD;
         en_state   <= RPR_OFF;
      end else begin
         slave_word <= next_slave_word;
         en_state   <= next_en_state;
      end
   end

   // Async enable gates without waiting for an edge of the sync path
   always_comb begin
      data_out.data = slave_word;
      data_out.oe_n = !((en_state == RPR_ON) && !async_en_n_s);
   end

   // Array is a constant parameter, so no bit can change: hold by build

   a_off_sync_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en && sync_en_n_s) |=> data_out.oe_n)
      else $error("sync enable high did not turn outputs off");

   a_off_async_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      async_en_n_s |-> data_out.oe_n)
      else $error("async enable high but outputs driven");

   drive_cond_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en && !sync_en_n_s) ##1 !async_en_n_s |-> !data_out.oe_n)
      else $error("outputs not driven with both enables low");

   word_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      clk_en |=> data_out.data == $past(master_word))
      else $error("output word not loaded from master stage");

   word_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !clk_en |=> $stable(data_out.data) && $stable(en_state))
      else $error("output word changed without an enabled edge");

   preset_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en && !preset_n_s) |=> data_out.data == PRESET_WORD)
      else $error("preset word not loaded on edge");

   addr_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en && preset_n_s) |=>
         data_out.data == CONTENTS[$past(addr_s)*`RPR_DATA_W +: `RPR_DATA_W])
      else $error("addressed word not loaded on edge");

   start_off_a: assert property (@(posedge clk_sys)
      $fell(sys_rst) |-> data_out.oe_n)
      else $error("outputs driven right after reset");

   // Pipeline timing, counted in enabled edges:
   //   edge 1 - pin levels enter the first synchroniser stage
   //   edge 2 - second stage feeds the array and the enable flop
   //   edge 3 - output register and enable flop load
   // The async enable reaches the output gate after edge 2, one edge
   // ahead of the sync enable, so it can still cut a word in flight.
   // A frozen clock enable stretches every stage alike, so the synchroniser
   // checks below count clock cycles but only fire on back-to-back enabled edges.

   // Address bits reach the array two enabled edges after the pins
   addr_sync_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en ##1 clk_en) |=>
         (addr_s == $past(word_address, 2)))
      else $error("address synchroniser lost a bit");

   // Sync enable pin reaches the enable flop input
   gs_sync_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en ##1 clk_en) |=>
         (sync_en_n_s == $past(sync_output_enable_n, 2)))
      else $error("sync enable synchroniser lost its level");

   // Async enable pin reaches the output gate
   g_sync_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en ##1 clk_en) |=>
         (async_en_n_s == $past(async_output_enable_n, 2)))
      else $error("async enable synchroniser lost its level");

   // Preset select reaches the array mux
   ps_sync_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en ##1 clk_en) |=>
         (preset_n_s == $past(preset_sel_n, 2)))
      else $error("preset select synchroniser lost its level");

   // Enable flop turns on after a low sync enable
   en_on_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en && !sync_en_n_s) |=>
         (en_state == RPR_ON))
      else $error("enable flop did not turn on");

   // Enable flop turns off after a high sync enable
   en_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en && sync_en_n_s) |=>
         (en_state == RPR_OFF))
      else $error("enable flop did not turn off");

   // Outputs driven only with both enables active
   drive_only_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !data_out.oe_n |->
         ((en_state == RPR_ON) && !async_en_n_s))
      else $error("outputs driven without both enables");

   // Low preset select puts the extra word on the master stage
   master_preset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !preset_n_s |->
         (master_word == PRESET_WORD))
      else $error("extra word not selected");

   // High preset select passes the addressed array word
   master_addr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      preset_n_s |->
         (master_word == CONTENTS[addr_s*`RPR_DATA_W +: `RPR_DATA_W]))
      else $error("master stage does not hold the addressed word");

   // Synchronisers hold while the clock enable is low
   sync_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !clk_en |=>
         ($stable(addr_s) && $stable(sync_en_n_s) && $stable(async_en_n_s)
          && $stable(preset_n_s)))
      else $error("synchroniser moved while frozen");

   // Output register comes out of reset blank
   reset_word_a: assert property (@(posedge clk_sys)
      $fell(sys_rst) |->
         (data_out.data == `RPR_BLANK_WORD))
      else $error("output word not blank after reset");

   // All enables come out of reset in the off state
   reset_sync_a: assert property (@(posedge clk_sys)
      $fell(sys_rst) |->
         (sync_en_n_s && async_en_n_s && preset_n_s && (en_state == RPR_OFF)))
      else $error("enable path not off after reset");

   // A driven word is the one addressed one edge before
   drive_word_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clk_en && !sync_en_n_s && preset_n_s) ##1 !async_en_n_s |->
         (data_out.data == CONTENTS[$past(addr_s)*`RPR_DATA_W +: `RPR_DATA_W]))
      else $error("driven word is not the addressed word");

   // Output enable holds while frozen and the async gate is still
   oe_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !clk_en ##1 $stable(async_en_n_s) |->
         $stable(data_out.oe_n))
      else $error("output enable moved while frozen");
endmodule // registered_prom_read_path
`default_nettype wire

/* rpr_bus_model.sv */
// Data bus model that sees the three-state output group
`timescale 1ns/100ps
`default_nettype none
module rpr_bus_model
   import rpr_pkg::*;
(
   input  wire logic     clk_sys,
   input  wire rpr_out_t data_out,
   output rpr_word_t     bus
);
   rpr_word_t last;
   // Released bus flips each cycle, so a stale word never passes as driven
   assign bus = data_out.oe_n ? ~last : data_out.data;
   // Remember the last bus level
   always_ff @(posedge clk_sys) begin
      last <= bus;
   end
endmodule // rpr_bus_model
`default_nettype wire

/* tb.sv */
// Self-checking bench for the registered memory read path
`timescale 1ns/100ps
`default_nettype none
`include "rpr_consts.svh"
module tb;
   import rpr_pkg::*;
   localparam int W = `RPR_DEPTH * `RPR_DATA_W;
   function automatic rpr_word_t ref_word(int i);
      return rpr_word_t'(i * 37 + (i >> 3));
   endfunction
   function automatic logic [W-1:0] fill();
      for (int i = 0; i < `RPR_DEPTH; i++)
         fill[i*8+:8] = ref_word(i);
   endfunction
   localparam logic [W-1:0] CONT = fill();
   logic      clk_sys = 0, sys_rst = 1, clk_en = 1, chk = 0;
   logic      gs_n = 1, g_n = 1, ps_n = 1;
   rpr_addr_t addr = '0;
   rpr_out_t  data_out;
   rpr_out_t  exp_q = '{data: '0, oe_n: 1'b1};
   rpr_out_t  q[$];
   rpr_word_t bus;
   int        n_mismatch = 0, n_checks = 0, cyc = 0;

   registered_prom_read_path #(.CONTENTS(CONT)) i_registered_prom_read_path (
      .clk_sys              (clk_sys),
      .sys_rst              (sys_rst),
      .clk_en               (clk_en),
      .word_address         (addr),
      .sync_output_enable_n (gs_n),
      .async_output_enable_n(g_n),
      .preset_sel_n         (ps_n),
      .data_out             (data_out)
   );
   rpr_bus_model i_rpr_bus_model (.clk_sys(clk_sys), .data_out(data_out), .bus(bus));

   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;

   task automatic finish_test();
      if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic cmp_out(rpr_out_t e);
      n_checks++;
      if (data_out.oe_n !== e.oe_n || (!e.oe_n && bus !== e.data)) begin
         n_mismatch++;
         $display("[ERR] %0t output mismatch", $time);
      end
   endtask

   // Inputs held well past the pipeline depth; a frozen step keeps the old note
   task automatic step(logic en, rpr_addr_t a, logic s, logic g, logic p);
      clk_en = en;
      addr = a;
      gs_n = s;
      g_n = g;
      ps_n = p;
      if (en) exp_q = '{data: p ? ref_word(a) : `RPR_BLANK_WORD, oe_n: s | g};
      repeat (5) @(posedge clk_sys);
      #1;
      q.push_back(exp_q);
      chk = 1;
      @(posedge clk_sys);
      #1;
      chk = 0;
   endtask

   // Monitor takes the oldest note when a result is flagged
   always @(posedge clk_sys) begin
      if (chk) cmp_out(q.pop_front());
   end

   // Hang guard, well above the expected run length
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // Reset, directed corners, then random traffic
   initial begin
      void'($urandom(91));
      repeat (5) @(posedge clk_sys);
      #1;
      sys_rst = 0;
      step(0, 9'h1ff, 0, 0, 1);
      step(1, 9'h1ff, 0, 0, 1);
      step(1, 9'h000, 0, 0, 0);
      step(1, 9'h055, 1, 0, 1);
      step(1, 9'h0aa, 0, 1, 1);
      repeat (60) step(1'($urandom), 9'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
      finish_test();
   end
endmodule // tb
`default_nettype wire
